// ===== core/pair_buffer.sv
// two-entry valid/ready buffer for conversion results
`timescale 1ns/1ps
module pair_buffer #(
   parameter int W = 18,
   parameter int DEPTH = 2
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   // whole buffer state; flags kept as flops, not decoded
   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [CW-1:0] cnt;
      logic rdy;
      logic vld;
   } buf_t;
   buf_t st_ff;
   buf_t nxt_st;
   logic do_in;
   logic do_out;

   assign do_in = in_valid & st_ff.rdy;
   assign do_out = st_ff.vld & out_ready;

   // write, read and count update; full stalls the filler
   always_comb
   begin
      nxt_st = st_ff;
      if (do_in)
      begin
         nxt_st.mem[st_ff.wp] = in_data;
         nxt_st.wp = (32'(st_ff.wp) == DEPTH - 1) ? '0 : st_ff.wp + 1'b1;
      end
      if (do_out)
         nxt_st.rp = (32'(st_ff.rp) == DEPTH - 1) ? '0 : st_ff.rp + 1'b1;
      nxt_st.cnt = st_ff.cnt + CW'(do_in) - CW'(do_out);
      nxt_st.rdy = (nxt_st.cnt != CW'(DEPTH));
      nxt_st.vld = (nxt_st.cnt != '0);
   end

   // state register, synchronous reset to empty
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         st_ff <= '0;
         st_ff.rdy <= 1'b1;
      end
      else
         st_ff <= nxt_st;
   end

   assign in_ready = st_ff.rdy;
   assign out_valid = st_ff.vld;
   assign out_data = st_ff.mem[st_ff.rp];
endmodule

// ===== core/pin_sync.sv
// two flip-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module pin_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // asynchronous levels in, synchronised levels out
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   // first stage feeds only the second stage
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sync_t;
   sync_t st_ff;
   sync_t nxt_st;

   // shift the levels one stage per edge
   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.s1 = d;
      nxt_st.s2 = st_ff.s1;
   end

   // state register, synchronous reset
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end

   assign q = st_ff.s2;
endmodule

// ===== core/result_port_pkg.sv
// constants and shared types of the serial result port
package result_port_pkg;
   // result and chain geometry
   localparam int RESULT_BITS = 18;
   localparam int CHAIN_DELAY = 16;
   localparam logic [4:0] LAST_BIT = 5'h11;
   localparam logic [4:0] FULL_CNT = 5'h12;
   // clock rate and quarter of a generated bit period
   localparam int CLK_MHZ = 10;
   localparam int QTR_NS = 100;
   localparam int QTR_RAW = (QTR_NS * CLK_MHZ + 999) / 1000;
   localparam int QTR_CYC = (QTR_RAW < 1) ? 1 : QTR_RAW;
   localparam logic [7:0] QTR_CYC8 = 8'(QTR_CYC);
   // register byte offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STAT_OFS = 8'h04;
   localparam logic [7:0] RES_OFS = 8'h08;
   // interface mode that selects the serial port
   localparam logic [1:0] MODE_SERIAL = 2'h3;
   // shared pin positions in serial mode
   localparam int PIN_DIV0 = 0;
   localparam int PIN_DIV1 = 1;
   localparam int PIN_CHAIN = 5;
   localparam int PIN_SDO = 6;
   localparam int PIN_SCLK = 7;
   // parallel result bits carried by the shared pins
   localparam int PAR_LSB = 4;
   localparam int PAR_MSB = 11;
   // status layout: error count position
   localparam int STAT_ERR_LSB = 8;
   // control register, bits 8..0: div, fmt, rdc, inv, pol, src, mode
   typedef struct packed {
      logic [1:0] div;
      logic fmt;
      logic read_during_conversion;
      logic inv;
      logic pol;
      logic src;
      logic [1:0] mode;
   } ctrl_t;
   // reset: serial mode, straight binary, master, rising edges
   localparam logic [8:0] CTRL_RST = 9'h043;
   // shifter states
   typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_HOLD} shift_st_t;
endpackage

// ===== core/serial_result_port.sv
// serial result port of the converter with an AHB-Lite register slave
//
// Added by the designer: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module serial_result_port
   import result_port_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // conversion core side
   input wire logic conv_busy,
   input wire logic res_valid,
   output logic res_ready,
   input wire logic [17:0] res_data,
   // shared pins, bits 4..11 of the parallel bus
   input wire logic [7:0] pin_in,
   output logic [7:0] pin_out,
   output logic [7:0] pin_oe,
   // chip select from host, active low
   input wire logic cs_n_pin,
   // frame marker and read error pins
   output logic frame_marker_out,
   output logic read_error_flag
);
   import result_port_pkg::*;

   // whole block state
   typedef struct packed {
      ctrl_t ctrl;
      shift_st_t st;
      logic [17:0] sr;
      logic [15:0] chain_dly;
      logic [4:0] bit_cnt;
      logic [1:0] qtr;
      logic [7:0] div_cnt;
      logic sclk;
      logic frame;
      logic sdo;
      logic rd_err;
      logic [7:0] err_cnt;
      logic [17:0] last;
      logic busy_d;
      logic cs_d;
      logic eclk_d;
      logic [7:0] pout;
      logic [7:0] poe;
      logic marker;
      logic [31:0] rdata;
      logic rdyout;
      logic wr_pend;
      logic [7:0] waddr;
   } port_state_t;
   port_state_t st_ff;
   port_state_t nxt_st;

   // synchronised pins
   logic eclk_s;
   logic chain_s;
   logic cs_s;
   // buffer drain side
   logic buf_valid;
   logic [17:0] buf_data;
   logic pop;
   // decoded mode and events
   logic serial;
   logic master;
   logic slave;
   logic push;
   logic busy_rise;
   logic cs_fall;
   logic edge_act;
   logic m_start;
   logic s_start;
   logic tick;
   logic accept;
   logic [7:0] div_lim;
   logic [17:0] ld_word;

   // external clock, chain input and select pass two flops
   pin_sync #(.W(3)) u_sync (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .d({pin_in[PIN_SCLK], pin_in[PIN_CHAIN], cs_n_pin}),
      .q({eclk_s, chain_s, cs_s})
   );

   // results wait here; a full buffer stalls the conversion core
   pair_buffer #(.W(RESULT_BITS), .DEPTH(2)) u_buf (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .in_valid(res_valid),
      .in_ready(res_ready),
      .in_data(res_data),
      .out_valid(buf_valid),
      .out_ready(pop),
      .out_data(buf_data)
   );

   // output coding: top bit inverted for twos complement
   function automatic logic [17:0] code_word(input logic [17:0] w,
                                             input logic f);
      code_word = f ? w : {~w[17], w[16:0]};
   endfunction

   // mode decode
   assign serial = (st_ff.ctrl.mode == MODE_SERIAL);
   assign master = serial & ~st_ff.ctrl.src;
   assign slave = serial & st_ff.ctrl.src;
   // conversion end is a word entering the buffer
   assign push = res_valid & res_ready;
   assign busy_rise = conv_busy & ~st_ff.busy_d;
   // select is active low: falling level opens a slave frame
   assign cs_fall = st_ff.cs_d & ~cs_s;
   // active external edge per invert select
   assign edge_act = st_ff.ctrl.inv ? (st_ff.eclk_d & ~eclk_s)
                                    : (~st_ff.eclk_d & eclk_s);
   // master start: after conversion, or with previous word during it
   assign m_start = master & (st_ff.st == ST_IDLE) & buf_valid &
                    (st_ff.ctrl.read_during_conversion ? busy_rise : ~conv_busy);
   assign s_start = slave & (st_ff.st == ST_IDLE) & cs_fall;
   // parallel modes drain the buffer straight into the hold register
   assign pop = buf_valid & (m_start | s_start | ~serial);
   assign tick = (st_ff.div_cnt == 8'h00);
   // divider only counts in master read-after; ignored otherwise
   assign div_lim = (master & ~st_ff.ctrl.read_during_conversion)
                  ? 8'((QTR_CYC8 << st_ff.ctrl.div) - 8'h01)
                  : 8'(QTR_CYC8 - 8'h01);
   // slave start with an empty buffer repeats the held word
   assign ld_word = code_word(pop ? buf_data : st_ff.last,
                              st_ff.ctrl.fmt);
   assign accept = hsel & htrans[1] & hready;

   // next state of the whole block
   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.busy_d = conv_busy;
      nxt_st.cs_d = cs_s;
      nxt_st.eclk_d = eclk_s;
      nxt_st.rd_err = 1'b0;
      nxt_st.rdyout = 1'b1;
      // on-chip hold register for the latest result
      if (pop)
         nxt_st.last = buf_data;
      // generated clock divider runs only while master shifts
      if (st_ff.st == ST_SHIFT && master && !tick)
         nxt_st.div_cnt = st_ff.div_cnt - 8'h01;
      else
         nxt_st.div_cnt = div_lim;
      case (st_ff.st)
         ST_IDLE:
         begin
            // load the shifter, first bit out at once
            if (m_start || s_start)
            begin
               nxt_st.st = ST_SHIFT;
               nxt_st.sr = ld_word;
               nxt_st.sdo = ld_word[17];
               nxt_st.bit_cnt = 5'h00;
               nxt_st.qtr = 2'h0;
               nxt_st.sclk = 1'b0;
               nxt_st.chain_dly = 16'h0000;
               nxt_st.frame = m_start;
            end
         end
         ST_SHIFT:
         begin
            if (!serial)
            begin
               // leaving serial mode drops the frame
               nxt_st.st = ST_IDLE;
               nxt_st.frame = 1'b0;
               nxt_st.sdo = 1'b0;
            end
            else if (master)
            begin
               // four quarters per bit; edges mid-bit keep data stable
               if (tick)
               begin
                  nxt_st.qtr = st_ff.qtr + 2'h1;
                  if (st_ff.qtr == 2'h0)
                     nxt_st.sclk = 1'b1;
                  if (st_ff.qtr == 2'h2)
                     nxt_st.sclk = 1'b0;
                  if (st_ff.qtr == 2'h3)
                  begin
                     if (st_ff.bit_cnt == LAST_BIT)
                     begin
                        // all eighteen bits sent, frame ends
                        nxt_st.st = ST_IDLE;
                        nxt_st.frame = 1'b0;
                        nxt_st.sdo = 1'b0;
                     end
                     else
                     begin
                        nxt_st.bit_cnt = st_ff.bit_cnt + 5'h01;
                        nxt_st.sr = {st_ff.sr[16:0], 1'b0};
                        nxt_st.sdo = st_ff.sr[16];
                     end
                  end
               end
            end
            else if (cs_s)
            begin
               // select released, frame over
               nxt_st.st = ST_IDLE;
               nxt_st.sdo = 1'b0;
            end
            else if (push && st_ff.bit_cnt < FULL_CNT)
            begin
               // unfinished read at conversion end: word is lost
               nxt_st.st = ST_HOLD;
               nxt_st.rd_err = 1'b1;
               nxt_st.err_cnt = st_ff.err_cnt + 8'h01;
               nxt_st.sdo = 1'b0;
            end
            else if (edge_act)
            begin
               // shift on the active host edge; chain trails the word
               if (st_ff.bit_cnt != 5'h1F)
                  nxt_st.bit_cnt = st_ff.bit_cnt + 5'h01;
               nxt_st.sr = {st_ff.sr[16:0], 1'b0};
               nxt_st.chain_dly = {st_ff.chain_dly[14:0], chain_s};
               if (st_ff.bit_cnt < LAST_BIT)
                  nxt_st.sdo = st_ff.sr[16];
               else
                  nxt_st.sdo = st_ff.chain_dly[CHAIN_DELAY-1];
            end
         end
         ST_HOLD:
         begin
            // after an error the output idles until select rises
            nxt_st.sdo = 1'b0;
            if (cs_s || !serial)
               nxt_st.st = ST_IDLE;
         end
         default:
            nxt_st.st = ST_IDLE;
      endcase
      // shared pins: parallel result bits or serial functions
      if (serial)
      begin
         // divider pins stay undriven in every serial mode
         nxt_st.pout = 8'h00;
         nxt_st.poe = 8'h00;
         nxt_st.pout[PIN_SDO] = nxt_st.sdo;
         nxt_st.poe[PIN_SDO] = 1'b1;
         nxt_st.pout[PIN_SCLK] = nxt_st.sclk ^ st_ff.ctrl.inv;
         nxt_st.poe[PIN_SCLK] = ~st_ff.ctrl.src;
      end
      else
      begin
         // ld_word already codes the word that the hold register takes
         nxt_st.pout = ld_word[PAR_MSB:PAR_LSB];
         nxt_st.poe = 8'hFF;
      end
      // marker only in master mode, polarity from pol
      nxt_st.marker = master & (nxt_st.frame ^ st_ff.ctrl.pol);
      if (master && !nxt_st.frame)
         nxt_st.marker = st_ff.ctrl.pol;
      // register write in the data phase
      if (st_ff.wr_pend && st_ff.waddr == CTRL_OFS)
         nxt_st.ctrl = ctrl_t'(hwdata[8:0]);
      nxt_st.wr_pend = accept & hwrite;
      nxt_st.waddr = haddr[7:0];
      // read data prepared in the address phase, zero wait
      nxt_st.rdata = 32'h0000_0000;
      if (accept && !hwrite)
      begin
         case (haddr[7:0])
            CTRL_OFS: nxt_st.rdata = 32'(st_ff.ctrl);
            STAT_OFS:
            begin
               nxt_st.rdata = 32'({buf_valid, st_ff.st != ST_IDLE,
                                   st_ff.frame});
               nxt_st.rdata[STAT_ERR_LSB +: 8] = st_ff.err_cnt;
            end
            RES_OFS: nxt_st.rdata = 32'(st_ff.last);
            default: nxt_st.rdata = 32'h0000_0000;
         endcase
      end
   end

   // state register, synchronous reset
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         st_ff <= '0;
         st_ff.ctrl <= ctrl_t'(CTRL_RST);
         st_ff.rdyout <= 1'b1;
         // select history starts low like its synchroniser: no false fall
      end
      else
         st_ff <= nxt_st;
   end

   assign hreadyout = st_ff.rdyout;
   assign hrdata = st_ff.rdata;
   assign hresp = st_ff.wr_pend & 1'b0;
   assign pin_out = st_ff.pout;
   assign pin_oe = st_ff.poe;
   assign frame_marker_out = st_ff.marker;
   assign read_error_flag = st_ff.rd_err;

   AST_PAR_PINS: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !serial |=> (pin_oe == 8'hFF))
      else $error("parallel mode pins not driven");
   AST_DIV_HIZ: assert property (@(posedge ref_clk) disable iff (sys_rst)
      serial |=> (pin_oe[PIN_DIV1:PIN_DIV0] == 2'h0))
      else $error("divider pins driven in serial mode");
   AST_CLK_DIR: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (serial && !sys_rst) |=> (pin_oe[PIN_SCLK] == !$past(st_ff.ctrl.src)))
      else $error("clock pin direction wrong");
   AST_MARKER: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (st_ff.frame && $past(master)) |->
      (frame_marker_out == !$past(st_ff.ctrl.pol)))
      else $error("frame marker level wrong");
   AST_STABLE_DATA: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (master && st_ff.frame && $past(st_ff.frame) &&
       $changed(st_ff.sclk)) |-> $stable(st_ff.sdo))
      else $error("serial data moved on a clock edge");
   AST_FULL_WORD: assert property (@(posedge ref_clk) disable iff (sys_rst)
      ($fell(st_ff.frame) && $past(master)) |->
      ($past(st_ff.bit_cnt) == LAST_BIT))
      else $error("master frame ended early");
   AST_FIRST_BIT: assert property (@(posedge ref_clk) disable iff (sys_rst)
      m_start |=> (st_ff.sdo == ($past(st_ff.ctrl.fmt) ?
                   $past(buf_data[17]) : !$past(buf_data[17]))))
      else $error("first bit coding wrong");
   AST_RD_ERR: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (slave && st_ff.st == ST_SHIFT && !cs_s && push &&
       st_ff.bit_cnt < FULL_CNT) |=> read_error_flag ##1 !read_error_flag)
      else $error("read error pulse missing");
   AST_SLAVE_EDGE: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (slave && $past(st_ff.st) == ST_SHIFT && st_ff.st == ST_SHIFT &&
       $changed(st_ff.sdo)) |-> $past(edge_act))
      else $error("slave data moved without active edge");
endmodule

// ===== test/adc_serial_result_port_bench.sv
// self-checking bench of the serial result port
`timescale 1ns/1ps
module adc_serial_result_port_bench;
   import result_port_pkg::*;
   // clock, reset and bus
   logic ref_clk;
   logic sys_rst;
   logic hsel;
   logic [31:0] haddr;
   logic [1:0] htrans;
   logic hwrite;
   logic [2:0] hsize;
   logic [31:0] hwdata;
   logic hreadyout;
   logic [31:0] hrdata;
   logic hresp;
   // converter side and pins
   logic conv_busy;
   logic res_valid;
   logic res_ready;
   logic [17:0] res_data;
   logic [7:0] pin_in;
   logic [7:0] pin_out;
   logic [7:0] pin_oe;
   logic cs_n;
   logic marker;
   logic err_flag;
   logic host_clk;
   logic host_chain;
   logic inv;
   logic pol;
   // bench state
   logic [31:0] rd;
   logic [23:0] got;
   ctrl_t c;
   int num_errors;
   int checked;
   int err_pulses;
   // wire level: whoever enables drives, else host or low
   assign pin_in = (pin_oe & pin_out) |
      (~pin_oe & {host_clk, 1'b0, host_chain, 5'h00});
   serial_result_port DUT (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .conv_busy(conv_busy), .res_valid(res_valid),
      .res_ready(res_ready), .res_data(res_data),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .cs_n_pin(cs_n), .frame_marker_out(marker),
      .read_error_flag(err_flag)
   );
   host_serial_model host (
      .ref_clk(ref_clk), .inv(inv), .pol(pol), .sdo(pin_out[6]),
      .mclk(pin_out[7]), .marker(marker), .sclk(host_clk),
      .chain(host_chain), .cs_n(cs_n)
   );
   // 10 MHz clock
   initial
   begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   // count cycles with the error flag high
   always @(posedge ref_clk)
      if (err_flag === 1'b1)
         err_pulses++;
   // compare one value and count it
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e)
      begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // one single AHB-Lite transfer, entered just after an edge
   task automatic ahb(input logic w, input logic [7:0] a,
                      input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h000000, a};
      hwrite <= w;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   // read a register and compare
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      ahb(1'b0, a, 32'h00000000);
      chk(rd, e);
   endtask
   // offer one result until the buffer takes it
   task automatic push(input logic [17:0] w);
      res_valid <= 1'b1;
      res_data <= w;
      do @(posedge ref_clk); while (res_ready !== 1'b1);
      res_valid <= 1'b0;
      // let an edge pass so a following push never re-raises valid
      @(posedge ref_clk);
   endtask
   // one master frame with its hold-off and timing checks
   task automatic m_frame(input ctrl_t k, input logic [17:0] w);
      int n;
      int len;
      n = 0;
      len = 72 * QTR_CYC * (k.read_during_conversion ? 1 : (1 << k.div));
      pol <= k.pol;
      inv <= k.inv;
      ahb(1'b1, CTRL_OFS, {23'h0, k});
      rdchk(CTRL_OFS, {23'h0, k});
      chk({24'h0, pin_oe}, 32'h000000C0);
      // busy level that must hold the frame back
      conv_busy <= ~k.read_during_conversion;
      host.clear();
      push(w);
      repeat (10) @(posedge ref_clk);
      chk(host.m_len, 0);
      conv_busy <= k.read_during_conversion;
      while (!host.m_done && n < 2000)
      begin
         @(posedge ref_clk);
         n++;
      end
      conv_busy <= 1'b0;
      chk(n < 2000, 1);
      chk(host.m_cnt, 18);
      chk(host.m_word, k.fmt ? w : {~w[17], w[16:0]});
      chk(host.m_bad, 0);
      chk(host.m_len >= len && host.m_len <= len + 2, 1);
      chk(marker, k.pol);
   endtask
   // print the counts and the verdict, then stop
   task automatic end_sim();
      $display("errors %0d checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // watchdog: a few thousand cycles are needed, allow far more
   initial
   begin
      repeat (30000) @(posedge ref_clk);
      num_errors++;
      end_sim();
   end
   // main sequence
   initial
   begin
      {hsel, haddr, htrans, hwrite, hwdata} = '0;
      hsize = 3'h2;
      {conv_busy, res_valid, res_data, inv, pol} = '0;
      {num_errors, checked, err_pulses} = '0;
      sys_rst = 1'b1;
      repeat (16) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(posedge ref_clk);
      rdchk(CTRL_OFS, {23'h0, CTRL_RST});
      chk({hresp, res_ready, err_flag}, 3'h2);
      // unmapped place: write dropped, read zero
      ahb(1'b1, 8'h0C, 32'hFFFFFFFF);
      rdchk(8'h0C, 32'h00000000);
      // master, read after conversion, every divider
      for (int i = 0; i < 4; i++)
         m_frame(ctrl_t'{i[1:0], i[0], 1'b0, i[0] ^ i[1], i[1], 1'b0,
            MODE_SERIAL}, 18'h2C5A3 ^ 18'(i * 4369));
      // master, read during conversion, divider ignored
      m_frame(ctrl_t'{2'h3, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0,
         MODE_SERIAL}, 18'h20001);
      // slave on both edges; buffer filled then drained
      for (int k = 0; k < 2; k++)
      begin
         c = ctrl_t'{2'h0, 1'b1, 1'b0, k[0], 1'b0, 1'b1, MODE_SERIAL};
         inv <= k[0];
         pol <= 1'b0;
         ahb(1'b1, CTRL_OFS, {23'h0, c});
         repeat (2) @(posedge ref_clk);
         chk({24'h0, pin_oe}, 32'h00000040);
         push(18'h3A5C1);
         push(18'h05A3E);
         @(posedge ref_clk);
         chk(res_ready, 1'b0);
         host.s_read(22, 1'b1, got);
         chk(got, {18'h3A5C1, 4'hF});
         host.s_read(18, 1'b0, got);
         chk(got, {6'h00, 18'h05A3E});
         ahb(1'b0, STAT_OFS, 32'h00000000);
         chk(rd & 32'h0000FF04, 32'h00000000);
      end
      chk(err_pulses, 0);
      // conversion ends in mid-read: word lost, flag pulsed
      push(18'h1FFFF);
      fork
         host.s_read(18, 1'b0, got);
         begin
            repeat (40) @(posedge ref_clk);
            push(18'h2AAAA);
         end
      join
      chk(err_pulses, 1);
      chk(got[11:0], 12'h000);
      ahb(1'b0, STAT_OFS, 32'h00000000);
      chk(rd[15:8], 8'h01);
      // parallel modes turn the shared pins into outputs
      for (int m = 0; m < 3; m++)
      begin
         ahb(1'b1, CTRL_OFS, {23'h0, 2'h0, 1'b1, 4'h0, m[1:0]});
         repeat (2) @(posedge ref_clk);
         chk({24'h0, pin_oe}, 32'h000000FF);
         chk({24'h0, pin_out}, 32'h000000AA);
      end
      rdchk(RES_OFS, 32'h0002AAAA);
      end_sim();
   end
endmodule

// ===== test/host_serial_model.sv
// host serial port model facing the result port pins
`timescale 1ns/1ps
module host_serial_model (
   // system clock for sampling the master link
   input wire logic ref_clk,
   // link settings shared with the device
   input wire logic inv,
   input wire logic pol,
   // pins driven by the device
   input wire logic sdo,
   input wire logic mclk,
   input wire logic marker,
   // pins driven by the host
   output logic sclk,
   output logic chain,
   output logic cs_n
);
   logic act; // host clock in its active phase
   logic last_clk; // master clock one cycle ago
   logic last_bit; // bit taken at the last active edge
   logic m_done; // a master frame has ended
   logic clr_req; // counts are wiped at the next edge
   int m_cnt; // bits taken in the master frame
   int m_len; // cycles the marker stood active
   int m_bad; // data changes seen at inactive edges
   logic [17:0] m_word; // master frame, first bit on top
   // host clock rests at the inactive level outside frames
   assign sclk = inv ^ act;
   initial
   begin
      act = 1'b0;
      chain = 1'b0;
      cs_n = 1'b1;
      last_clk = 1'b0;
      clr_req = 1'b1;
   end
   // master capture: take on active edge, recheck on inactive edge
   always @(posedge ref_clk)
   begin
      last_clk <= mclk;
      if (clr_req)
      begin
         // wipe at an edge so the counts never race this sampler
         clr_req <= 1'b0;
         m_cnt <= 0;
         m_len <= 0;
         m_bad <= 0;
         m_done <= 1'b0;
         m_word <= 18'h0;
      end
      else if (marker === ~pol)
      begin
         m_len <= m_len + 1;
         if (mclk !== last_clk && mclk === ~inv)
         begin
            m_word <= {m_word[16:0], sdo};
            last_bit <= sdo;
            m_cnt <= m_cnt + 1;
         end
         // data must not move at the inactive edge
         else if (mclk !== last_clk && sdo !== last_bit)
            m_bad <= m_bad + 1;
      end
      else if (m_len > 0)
         m_done <= 1'b1;
   end
   // forget the previous master frame at the next edge
   task automatic clear();
      clr_req = 1'b1;
   endtask
   // slave frame: select, n periods of 800 ns, release
   task automatic s_read(input int n, input logic ch,
                         output logic [23:0] got);
      got = 24'h0;
      chain <= ch;
      #37 cs_n <= 1'b0;
      #800;
      // sample before each active edge, clock gated by select
      for (int i = 0; i < n; i++)
      begin
         got = {got[22:0], sdo};
         act <= 1'b1;
         #400 act <= 1'b0;
         #400;
      end
      cs_n <= 1'b1;
      #800;
      @(posedge ref_clk);
   endtask
endmodule
